/* core/tpc_pkg.sv */
// Constants, field layouts and state types of the port power control and CC status block.
// Assumes register accesses arrive already decoded from the serial host port.
package tpc_pkg;
  localparam logic [7:0] ADDR_PWR_CTRL = 8'h1c;
  localparam logic [7:0] ADDR_CC_STAT  = 8'h1d;
  // Power control field positions
  localparam int unsigned B_MON_OFF   = 6;
  localparam int unsigned B_ALARM_OFF = 5;
  localparam int unsigned B_AUTO      = 4;
  localparam int unsigned B_TRICKLE   = 3;
  localparam int unsigned B_FORCE     = 2;
  localparam int unsigned B_LEVEL     = 1;
  localparam int unsigned B_VCONN     = 0;
  localparam logic [7:0] PWR_CTRL_RST   = 8'h60;
  localparam logic [7:0] PWR_CTRL_WMASK = 8'h75;
  // CC status field positions
  localparam int unsigned B_SEEK   = 5;
  localparam int unsigned B_RESULT = 4;
  localparam int unsigned L2_LSB   = 2;
  localparam int unsigned L1_LSB   = 0;
  localparam logic [1:0] CODE_OPEN = 2'h0;
  localparam logic [1:0] CODE_RA   = 2'h1;
  localparam logic [1:0] CODE_RD   = 2'h2;
  localparam logic [1:0] CODE_RSVD = 2'h3;
  localparam logic [1:0] ROLE_OPEN = 2'h3;
  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned DEBOUNCE_NS    = 375000;
  localparam int unsigned DEBOUNCE_CYC   = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned UPDATE_MAX_NS  = 50000;
  localparam int unsigned UPDATE_MAX_CYC = UPDATE_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned DEB_CNT_W      = 16;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } tpc_reg_req_s;

  typedef enum logic [1:0] {
    DRAIN_IDLE = 2'h0,
    DRAIN_STOP = 2'h1,
    DRAIN_ON   = 2'h3
  } tpc_drain_e;

  typedef struct packed {
    logic [1:0]           cand;
    logic [DEB_CNT_W-1:0] cnt;
    logic [1:0]           stable;
  } tpc_filt_st_s;

  typedef struct packed {
    logic [7:0] ctrl;
    logic       pend;
    logic [7:0] pend_d;
    logic [7:0] stat;
    logic [7:0] rdata;
    logic       rvalid;
    tpc_drain_e drain;
    logic       src_off;
    logic       drn_out;
    logic       alarm_en;
    logic       mon_en;
    logic       cbl_line2;
    logic       chg;
  } tpc_regs_st_s;
endpackage : tpc_pkg

/* core/tpc_line_filter.sv */
// Debounce filter for one two-bit CC line state.
// Assumes the raw code is synchronous to clk_i.
`timescale 1ns/100ps
module tpc_line_filter #(
  parameter int unsigned DEB_CYC = tpc_pkg::DEBOUNCE_CYC // Cycles a code must hold
) (
  input  wire logic       clk_i,     // System clock
  input  wire logic       reset_n_i, // Async reset, active low
  input  wire logic [1:0] raw_i,     // Raw line code
  output logic      [1:0] stable_o   // Debounced line code
);
  tpc_pkg::tpc_filt_st_s st_r;
  tpc_pkg::tpc_filt_st_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (raw_i != st_r.cand) begin
      st_nxt.cand = raw_i;
      st_nxt.cnt  = '0;
    end else if (st_r.cand != st_r.stable) begin
      if (st_r.cnt == tpc_pkg::DEB_CNT_W'(DEB_CYC - 1)) begin
        st_nxt.stable = st_r.cand;
        st_nxt.cnt    = '0;
      end else begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stable_o = st_r.stable;

  a_filter_settle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $changed(st_r.stable) |-> $past(raw_i) == st_r.stable && $past(st_r.cand) == st_r.stable)
    else $error("debounced code changed to a value not held on the line");
endmodule : tpc_line_filter

/* core/tpc_power_cc_regs.sv */
// Power control and CC line status registers of a source-only Type-C port.
// Assumes a serial host front end that presents decoded byte accesses,
// and role, orientation, fault and shield signals from neighbouring logic.
`timescale 1ns/100ps
module tpc_power_cc_regs #(
  parameter int unsigned DEB_CYC = tpc_pkg::DEBOUNCE_CYC // Line debounce length
) (
  input  wire logic                  clk_i,                 // 100 MHz clock
  input  wire logic                  reset_n_i,             // Async reset, active low
  input  wire tpc_pkg::tpc_reg_req_s req_i,                 // Decoded register access
  input  wire logic                  fault_a_i,             // Fault action A in effect
  input  wire logic                  plug_flip_i,           // Plug orientation
  input  wire logic [1:0]            role_line1_i,          // Line 1 pull-up role
  input  wire logic [1:0]            role_line2_i,          // Line 2 pull-up role
  input  wire logic [1:0]            line1_raw_i,           // Line 1 detector code
  input  wire logic [1:0]            line2_raw_i,           // Line 2 detector code
  input  wire logic                  seeking_attach_i,      // Attach search running
  input  wire logic                  shield_gate_drive_i,   // Shield gate drive high
  input  wire logic                  shield_guard_active_i, // Shield protection active
  output logic      [7:0]            reg_rdata_o,           // Read data
  output logic                       reg_rvalid_o,          // Read data valid
  output logic                       vbus_alarm_report_o,   // Alarm reporting enabled
  output logic                       vbus_monitor_en_o,     // Bus monitor enabled
  output logic                       vbus_source_off_o,     // Stop sourcing bus power
  output logic                       vbus_drain_o,          // Discharge bus
  output logic                       cable_supply_en_o,     // Cable supply on
  output logic                       cable_supply_line2_o,  // Cable supply on line 2
  output logic                       cc_change_flag_o       // CC status changed pulse
);

  localparam int unsigned BMON = tpc_pkg::B_MON_OFF;
  localparam int unsigned BALR = tpc_pkg::B_ALARM_OFF;
  localparam int unsigned BAUT = tpc_pkg::B_AUTO;
  localparam int unsigned BTRK = tpc_pkg::B_TRICKLE;
  localparam int unsigned BFRC = tpc_pkg::B_FORCE;
  localparam int unsigned BLVL = tpc_pkg::B_LEVEL;
  localparam int unsigned BVCN = tpc_pkg::B_VCONN;
  localparam int unsigned BSK  = tpc_pkg::B_SEEK;
  localparam int unsigned BRS  = tpc_pkg::B_RESULT;
  localparam int unsigned L1   = tpc_pkg::L1_LSB;
  localparam int unsigned L2   = tpc_pkg::L2_LSB;
  localparam logic [1:0] OPEN  = tpc_pkg::CODE_OPEN;
  localparam logic [1:0] RA    = tpc_pkg::CODE_RA;
  localparam logic [1:0] RSVD  = tpc_pkg::CODE_RSVD;

  tpc_pkg::tpc_regs_st_s st_r;
  tpc_pkg::tpc_regs_st_s st_nxt;

  logic [1:0] raw  [2];
  logic [1:0] filt [2];
  logic       wr_hit;
  logic       rep_on;
  logic       disc;
  logic [7:0] stat_calc;

  assign raw[0] = line1_raw_i;
  assign raw[1] = line2_raw_i;

  // One debounce filter per CC line
  for (genvar g = 0; g < 2; g++) begin : g_line
    tpc_line_filter #(
      .DEB_CYC (DEB_CYC)
    ) u_filt (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .raw_i     (raw[g]),
      .stable_o  (filt[g])
    );
  end

  assign wr_hit = req_i.wr && (req_i.addr == tpc_pkg::ADDR_PWR_CTRL);

  // Reporting stays on unless both role fields are open
  assign rep_on = !((role_line1_i == tpc_pkg::ROLE_OPEN) &&
                    (role_line2_i == tpc_pkg::ROLE_OPEN));

  // Disconnect is judged on the line carried through the cable
  assign disc = plug_flip_i ? (st_r.stat[L2 +: 2] == OPEN)
                            : (st_r.stat[L1 +: 2] == OPEN);

  always_comb begin
    logic [1:0] s1;
    logic [1:0] s2;
    s1 = filt[0];
    s2 = filt[1];
    // Reserved detector code never reaches software
    if (s1 == RSVD) begin
      s1 = OPEN;
    end
    if (s2 == RSVD) begin
      s2 = OPEN;
    end
    // A floating shield makes Ra/Rd unreliable
    if (!shield_gate_drive_i) begin
      s1 = OPEN;
      s2 = OPEN;
    end
    // A bare marked cable looks like Ra/open; hide it while seeking
    if (seeking_attach_i && (((s1 == RA) && (s2 == OPEN)) ||
                             ((s1 == OPEN) && (s2 == RA)))) begin
      s1 = OPEN;
      s2 = OPEN;
    end
    // The line carrying cable supply reads open
    if (st_r.ctrl[BVCN]) begin
      if (plug_flip_i) begin
        s1 = OPEN;
      end else begin
        s2 = OPEN;
      end
    end
    stat_calc           = 8'h00;
    stat_calc[BSK]      = seeking_attach_i;
    stat_calc[BRS]      = 1'b0;
    stat_calc[L2 +: 2]  = s2;
    stat_calc[L1 +: 2]  = s1;
    if (!rep_on) begin
      stat_calc = 8'h00;
    end
  end

  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.chg    = 1'b0;

    // Power control write path
    if (fault_a_i) begin
      if (wr_hit) begin
        st_nxt.pend   = 1'b1;
        st_nxt.pend_d = req_i.wdata;
      end
    end else if (wr_hit) begin
      st_nxt.ctrl = req_i.wdata & tpc_pkg::PWR_CTRL_WMASK;
      st_nxt.pend = 1'b0;
    end else if (st_r.pend) begin
      st_nxt.ctrl = st_r.pend_d & tpc_pkg::PWR_CTRL_WMASK;
      st_nxt.pend = 1'b0;
    end

    // Shield protection overrides any request to keep cable supply on
    if (shield_guard_active_i) begin
      st_nxt.ctrl[BVCN] = 1'b0;
    end

    st_nxt.alarm_en  = !st_nxt.ctrl[BALR];
    st_nxt.mon_en    = !st_nxt.ctrl[BMON];
    st_nxt.cbl_line2 = !plug_flip_i;

    // Status register and change flag
    st_nxt.stat = stat_calc;
    if (rep_on && (stat_calc != st_r.stat)) begin
      st_nxt.chg = 1'b1;
    end

    // Register reads
    if (req_i.rd) begin
      case (req_i.addr)
        tpc_pkg::ADDR_PWR_CTRL: begin
          st_nxt.rdata  = st_r.ctrl;
          st_nxt.rvalid = 1'b1;
        end
        tpc_pkg::ADDR_CC_STAT: begin
          st_nxt.rdata  = st_r.stat;
          st_nxt.rvalid = 1'b1;
        end
        default: begin
          st_nxt.rdata = 8'h00;
        end
      endcase
    end

    // Auto drain: stop sourcing first, discharge one cycle later
    case (st_r.drain)
      tpc_pkg::DRAIN_IDLE: begin
        if (st_r.ctrl[BAUT] && disc) begin
          st_nxt.drain = tpc_pkg::DRAIN_STOP;
        end
      end
      tpc_pkg::DRAIN_STOP: begin
        if (st_r.ctrl[BAUT] && disc) begin
          st_nxt.drain = tpc_pkg::DRAIN_ON;
        end else begin
          st_nxt.drain = tpc_pkg::DRAIN_IDLE;
        end
      end
      tpc_pkg::DRAIN_ON: begin
        if (!st_r.ctrl[BAUT] || !disc) begin
          st_nxt.drain = tpc_pkg::DRAIN_IDLE;
        end
      end
      default: begin
        st_nxt.drain = tpc_pkg::DRAIN_IDLE;
      end
    endcase
    st_nxt.src_off = (st_nxt.drain != tpc_pkg::DRAIN_IDLE);
    st_nxt.drn_out = (st_nxt.drain == tpc_pkg::DRAIN_ON) || st_nxt.ctrl[BFRC];
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r      <= '0;
      st_r.ctrl <= tpc_pkg::PWR_CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o          = st_r.rdata;
  assign reg_rvalid_o         = st_r.rvalid;
  assign vbus_alarm_report_o  = st_r.alarm_en;
  assign vbus_monitor_en_o    = st_r.mon_en;
  assign vbus_source_off_o    = st_r.src_off;
  assign vbus_drain_o         = st_r.drn_out;
  assign cable_supply_en_o    = st_r.ctrl[BVCN];
  assign cable_supply_line2_o = st_r.cbl_line2;
  assign cc_change_flag_o     = st_r.chg;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_alarm_follow: assert property (
    wr_hit && !fault_a_i |=> vbus_alarm_report_o == !$past(req_i.wdata[BALR]))
    else $error("alarm reporting does not follow the written disable bit");

  a_drain_order: assert property (
    $rose(vbus_drain_o) && !st_r.ctrl[BFRC] |-> $past(vbus_source_off_o))
    else $error("bus discharge started before sourcing stopped");

  a_disc_start: assert property (
    st_r.drain == tpc_pkg::DRAIN_IDLE && st_r.ctrl[BAUT] && !plug_flip_i &&
    st_r.stat[L1 +: 2] == OPEN |=> vbus_source_off_o)
    else $error("open connected line did not stop sourcing");

  a_trickle_zero: assert property (
    !st_r.ctrl[BTRK] && !(reg_rvalid_o && $past(req_i.addr) == tpc_pkg::ADDR_PWR_CTRL &&
    reg_rdata_o[BTRK]))
    else $error("bleed discharge bit is not zero");

  a_force_rw: assert property (
    wr_hit && !fault_a_i |=> st_r.ctrl[BFRC] == $past(req_i.wdata[BFRC]) ##1
    vbus_drain_o || !st_r.ctrl[BFRC])
    else $error("forced discharge bit not stored or not acted on");

  a_level_zero: assert property (
    !st_r.ctrl[BLVL])
    else $error("cable power level bit is not zero");

  a_vconn_blank: assert property (
    st_r.ctrl[BVCN] && !plug_flip_i |=> st_r.stat[L2 +: 2] == OPEN)
    else $error("cable supply line not reported open");

  a_shield_clear: assert property (
    shield_guard_active_i |=> !cable_supply_en_o)
    else $error("cable supply left on under shield protection");

  a_fault_block: assert property (
    fault_a_i && !shield_guard_active_i |=> st_r.ctrl == $past(st_r.ctrl))
    else $error("power control changed during fault action A");

  a_fault_apply: assert property (
    st_r.pend && !fault_a_i && !wr_hit && !shield_guard_active_i |=>
    st_r.ctrl == ($past(st_r.pend_d) & tpc_pkg::PWR_CTRL_WMASK))
    else $error("held write not applied after the fault ended");

  a_update_bound: assert property (
    rep_on && shield_gate_drive_i && !seeking_attach_i && !st_r.ctrl[BVCN] &&
    filt[0] != RSVD |=> st_r.stat[L1 +: 2] == $past(filt[0]))
    else $error("line 1 status not updated after debounce");

  a_report_off: assert property (
    !rep_on |=> st_r.stat == 8'h00 ##1 !(reg_rvalid_o && reg_rdata_o != 8'h00 &&
    $past(req_i.addr) == tpc_pkg::ADDR_CC_STAT && !rep_on))
    else $error("status not cleared while reporting is off");

  a_no_alert: assert property (
    !rep_on |=> !cc_change_flag_o)
    else $error("change flag raised by disabling reporting");

  a_seek_bit: assert property (
    rep_on |=> st_r.stat[BSK] == $past(seeking_attach_i))
    else $error("seeking flag does not follow the search");

  a_result_zero: assert property (
    !st_r.stat[BRS])
    else $error("attach result bit is not zero");

  a_no_rsvd: assert property (
    st_r.stat[L1 +: 2] != RSVD && st_r.stat[L2 +: 2] != RSVD)
    else $error("reserved line code reported");

  a_gate_open: assert property (
    !shield_gate_drive_i |=> st_r.stat[L1 +: 2] == OPEN && st_r.stat[L2 +: 2] == OPEN)
    else $error("Ra or Rd reported with the gate drive low");

  a_ra_pair: assert property (
    seeking_attach_i && filt[0] == RA && filt[1] == OPEN |=> st_r.stat[3:0] == 4'h0)
    else $error("Ra/open pair not hidden while seeking");

  a_role_blank: assert property (
    role_line1_i == tpc_pkg::ROLE_OPEN && role_line2_i == tpc_pkg::ROLE_OPEN |=>
    st_r.stat == 8'h00 && !cc_change_flag_o)
    else $error("status reported with both line roles open");

  a_supply_line: assert property (
    1'b1 |=> cable_supply_line2_o == !$past(plug_flip_i))
    else $error("cable supply line does not follow plug orientation");

  a_stat_read: assert property (
    req_i.rd && req_i.addr == tpc_pkg::ADDR_CC_STAT |=> reg_rvalid_o && !reg_rdata_o[BRS])
    else $error("status read not answered or attach result set");

  a_ctrl_read: assert property (
    req_i.rd && req_i.addr == tpc_pkg::ADDR_PWR_CTRL |=>
    reg_rvalid_o && !reg_rdata_o[BTRK] && !reg_rdata_o[BLVL])
    else $error("power control read not answered or fixed bits set");

  a_drain_leave: assert property (
    st_r.drain == tpc_pkg::DRAIN_ON && !st_r.ctrl[BAUT] && !st_r.ctrl[BFRC] &&
    !wr_hit && !st_r.pend |=> !vbus_drain_o)
    else $error("bus discharge kept on after auto drain was disabled");

  a_flag_change: assert property (
    $past(rep_on) |-> cc_change_flag_o == $changed(st_r.stat))
    else $error("change flag does not match a status update");

  a_pend_latest: assert property (
    fault_a_i && wr_hit |=> st_r.pend && st_r.pend_d == $past(req_i.wdata))
    else $error("write during fault action A not held");

  a_disc_flip: assert property (
    st_r.drain == tpc_pkg::DRAIN_IDLE && st_r.ctrl[BAUT] && plug_flip_i &&
    st_r.stat[L2 +: 2] == OPEN |=> vbus_source_off_o)
    else $error("open line 2 did not stop sourcing when flipped");

  a_no_disc: assert property (
    st_r.drain == tpc_pkg::DRAIN_IDLE && !plug_flip_i && st_r.stat[L1 +: 2] != OPEN |=>
    !vbus_source_off_o)
    else $error("sourcing stopped while the connected line is attached");

  c_ra_hidden: cover property (seeking_attach_i && filt[0] == RA && filt[1] == OPEN);
  c_auto_drain: cover property (st_r.drain == tpc_pkg::DRAIN_ON);
  c_fault_write: cover property (st_r.pend && !fault_a_i);
  c_shield_cut: cover property (cable_supply_en_o && shield_guard_active_i);
  c_seek_fall: cover property ($fell(st_r.stat[BSK]));
endmodule : tpc_power_cc_regs

/* tb/tpc_cable_model.sv */
// Cable-end model: drives both CC line detector codes, gate drive and search flag.
// Assumes the bench commands a plug pattern; outputs move on rising clk_i edges.
`timescale 1ns/100ps
module tpc_cable_model (
  input  wire logic       clk_i,     // System clock
  input  wire logic       reset_n_i, // Async reset, active low
  input  wire logic [5:0] cfg_i,     // Gate, seek, line 2, line 1 pattern
  output logic      [1:0] line1_o,   // Line 1 detector code
  output logic      [1:0] line2_o,   // Line 2 detector code
  output logic            gate_o,    // Shield gate drive
  output logic            seek_o     // Attach search running
);
  // Detector codes settle one clock after the plug pattern changes
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {gate_o, seek_o, line2_o, line1_o} <= 6'h00;
    end else begin
      {gate_o, seek_o, line2_o, line1_o} <= cfg_i;
    end
  end
endmodule : tpc_cable_model

/* tb/typec_power_ctrl_cc_status_test.sv */
// Self-checking bench for the power control and CC status registers.
// Assumes the cable model drives the line codes; the bench acts as host.
`timescale 1ns/100ps
module typec_power_ctrl_cc_status_test;
  localparam int unsigned DEB = 8;
  localparam int unsigned WIN = DEB + 20;
  localparam logic [7:0]  PC  = tpc_pkg::ADDR_PWR_CTRL;
  localparam logic [7:0]  ST  = tpc_pkg::ADDR_CC_STAT;
  logic                  clk_i;
  logic                  reset_n_i;
  tpc_pkg::tpc_reg_req_s req;
  logic                  fault;
  logic                  flip;
  logic                  guard;
  logic [1:0]            role1;
  logic [1:0]            role2;
  logic [5:0]            cfg;
  logic [1:0]            l1;
  logic [1:0]            l2;
  logic                  gate;
  logic                  seek;
  logic [7:0]            rdata;
  logic                  rvalid;
  logic                  alarm;
  logic                  mon;
  logic                  src_off;
  logic                  drain;
  logic                  cbl_en;
  logic                  cbl_l2;
  logic                  flag;
  logic                  seen;
  logic [5:0]            tab [7];
  int                    errors;
  int                    n_checks;

  tpc_cable_model u_cable (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .cfg_i(cfg),
    .line1_o(l1), .line2_o(l2), .gate_o(gate), .seek_o(seek)
  );
  tpc_power_cc_regs #(.DEB_CYC(DEB)) uut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req), .fault_a_i(fault),
    .plug_flip_i(flip), .role_line1_i(role1), .role_line2_i(role2),
    .line1_raw_i(l1), .line2_raw_i(l2), .seeking_attach_i(seek),
    .shield_gate_drive_i(gate), .shield_guard_active_i(guard),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .vbus_alarm_report_o(alarm),
    .vbus_monitor_en_o(mon), .vbus_source_off_o(src_off), .vbus_drain_o(drain),
    .cable_supply_en_o(cbl_en), .cable_supply_line2_o(cbl_l2),
    .cc_change_flag_o(flag)
  );

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chkb(input logic got, input logic exp, input string what);
    chk({7'h00, got}, {7'h00, exp}, what);
  endtask : chkb

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk_i);
    req.wr <= 1'b0;
    #1;
  endtask : wr

  // Answer is due exactly one cycle after the request edge
  task automatic rd(input logic [7:0] a, input logic v, input logic [7:0] e);
    @(posedge clk_i);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1;
    chkb(rvalid, v, "read valid");
    chk(rdata, e, "read data");
  endtask : rd

  // Watches a whole debounce window for the one-cycle change pulse
  task automatic settle(input logic exp);
    seen = 1'b0;
    repeat (WIN) begin
      @(posedge clk_i);
      #1;
      if (flag === 1'b1) seen = 1'b1;
    end
    chkb(seen, exp, "change flag");
  endtask : settle

  function automatic logic [7:0] exp_st(input logic [5:0] c, input logic vc, input logic fl);
    logic [1:0] a;
    logic [1:0] b;
    a = (c[1:0] == 2'h3 || !c[5]) ? 2'h0 : c[1:0];
    b = (c[3:2] == 2'h3 || !c[5]) ? 2'h0 : c[3:2];
    if (c[4] && ((a == 2'h1 && b == 2'h0) || (a == 2'h0 && b == 2'h1))) begin
      a = 2'h0;
      b = 2'h0;
    end
    if (vc && fl) a = 2'h0;
    if (vc && !fl) b = 2'h0;
    return {2'h0, c[4], 1'b0, b, a};
  endfunction : exp_st

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    reset_n_i = 1'b0;
    req = '0;
    fault = 1'b0;
    flip = 1'b0;
    guard = 1'b0;
    role1 = 2'h1;
    role2 = 2'h1;
    cfg = 6'h00;
    errors = 0;
    n_checks = 0;
    tab = '{6'h22, 6'h29, 6'h23, 6'h31, 6'h24, 6'h0a, 6'h36};
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(PC, 1'b1, 8'h60);
    chkb(alarm, 1'b0, "alarm report");
    rd(ST, 1'b1, 8'h00);
    wr(PC, 8'hff);
    rd(PC, 1'b1, 8'h75);
    wr(ST, 8'haa);
    rd(ST, 1'b1, 8'h00);
    rd(8'h1e, 1'b0, 8'h00);
    wr(PC, 8'h00);
    wait_cyc(2);
    chkb(mon, 1'b1, "monitor enable");
    chkb(alarm, 1'b1, "alarm report");
    wr(PC, 8'h04);
    wait_cyc(2);
    chkb(drain, 1'b1, "forced drain");
    wr(PC, 8'h00);
    wait_cyc(2);
    chkb(drain, 1'b0, "forced drain off");
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_i);
      cfg <= tab[i];
      settle(1'b1);
      rd(ST, 1'b1, exp_st(tab[i], 1'b0, 1'b0));
    end
    @(posedge clk_i);
    role1 <= 2'h3;
    role2 <= 2'h3;
    settle(1'b0);
    rd(ST, 1'b1, 8'h00);
    @(posedge clk_i);
    role1 <= 2'h1;
    role2 <= 2'h1;
    cfg <= 6'h2a;
    settle(1'b1);
    $display("test line status done");
    wr(PC, 8'h01);
    rd(ST, 1'b1, exp_st(6'h2a, 1'b1, 1'b0));
    chkb(cbl_l2, 1'b1, "supply on line 2");
    chkb(cbl_en, 1'b1, "supply on");
    @(posedge clk_i);
    flip <= 1'b1;
    wait_cyc(3);
    rd(ST, 1'b1, exp_st(6'h2a, 1'b1, 1'b1));
    chkb(cbl_l2, 1'b0, "supply on line 1");
    @(posedge clk_i);
    guard <= 1'b1;
    wait_cyc(3);
    rd(PC, 1'b1, 8'h00);
    chkb(cbl_en, 1'b0, "supply cut");
    @(posedge clk_i);
    guard <= 1'b0;
    $display("test cable supply done");
    @(posedge clk_i);
    fault <= 1'b1;
    wr(PC, 8'h04);
    wait_cyc(2);
    rd(PC, 1'b1, 8'h00);
    chkb(drain, 1'b0, "held write");
    @(posedge clk_i);
    fault <= 1'b0;
    wait_cyc(3);
    rd(PC, 1'b1, 8'h04);
    chkb(drain, 1'b1, "released write");
    wr(PC, 8'h00);
    $display("test fault hold done");
    for (int f = 0; f < 2; f++) begin
      @(posedge clk_i);
      flip <= f[0];
      cfg <= f[0] ? 6'h28 : 6'h22;
      settle(1'b1);
      wr(PC, 8'h10);
      wait_cyc(3);
      chkb(src_off, 1'b0, "attached source");
      @(posedge clk_i);
      cfg <= 6'h20;
      seen = 1'b0;
      for (int k = 0; k < WIN && !seen; k++) begin
        @(posedge clk_i);
        #1;
        seen = (src_off === 1'b1);
      end
      if (!seen) begin
        errors++;
        $display("Error at %0t: source never stopped", $time);
        final_report();
      end
      chkb(drain, 1'b0, "drain before stop");
      wait_cyc(1);
      chkb(drain, 1'b1, "drain after stop");
      wr(PC, 8'h00);
    end
    $display("test auto drain done");
    final_report();
  end
endmodule : typec_power_ctrl_cc_status_test
